// file: hdl/prcs_pkg.sv
package prcs_pkg;
    // Device register map, 7-bit serial address
    localparam logic [6:0] REG_VCO_CAL = 7'h0e;
    localparam logic [6:0] REG_DIV_CTRL = 7'h14;
    localparam logic [6:0] REG_DIV_VAL_A = 7'h15;
    localparam logic [6:0] REG_DIV_VAL_B = 7'h16;
    localparam logic [6:0] REG_DIV_VAL_C = 7'h17;
    localparam logic [6:0] REG_DIV_VAL_D = 7'h18;
    localparam logic [6:0] REG_CRYSTAL_INPUT = 7'h1b;
    localparam logic [6:0] REG_FB_LO = 7'h30;
    localparam logic [6:0] REG_FB_MID = 7'h31;
    localparam logic [6:0] REG_FB_HI = 7'h32;
    localparam logic [6:0] REG_CP = 7'h33;
    localparam logic [6:0] REG_PLL_CTRL = 7'h34;
    localparam logic [6:0] REG_REF_CFG = 7'h35;
    localparam int CAL_EN_BIT = 2;
    localparam int CAL_GO_BIT = 7;
    localparam int DIV_EN_BIT = 2;
    localparam int CRYSTAL_INPUT_PIN_BIT = 7;
    localparam int PLL_EN_BIT = 0;
    localparam int REF_DIFF_BIT = 0;
    localparam logic [7:0] CRYSTAL_INPUT_RST = 8'hbf;
    // Load capacitance in femtofarads
    localparam int CRYSTAL_INPUT_STEP_FF = 250;
    localparam int CRYSTAL_INPUT_DEF_FF = 2000;
    localparam logic [5:0] CRYSTAL_INPUT_DEF_CODE = 6'(CRYSTAL_INPUT_DEF_FF / CRYSTAL_INPUT_STEP_FF);
    localparam logic [4:0] CAL_CYCLES = 5'h10;
    // Serial frame: rw, 7-bit address, 8-bit data, msb first
    localparam logic [4:0] HDR_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [3:0] A_SPI = 4'h0;
    localparam logic [5:0] Y_SPI = 6'h00;
    // Host Wishbone map
    localparam logic [7:0] HW_CTRL = 8'h00;
    localparam logic [7:0] HW_ADDR = 8'h04;
    localparam logic [7:0] HW_WDATA = 8'h08;
    localparam logic [7:0] HW_RDATA = 8'h0c;
    localparam logic [7:0] HW_STATUS = 8'h10;
    localparam logic [7:0] HW_PINS = 8'h14;
    localparam logic [7:0] HW_OMODE = 8'h18;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_RD_BIT = 1;
    localparam logic [2:0] SCLK_HALF = 3'h4;

    typedef struct packed {
        logic valid;
        logic [19:0] n;
        logic [7:0] cp;
    } prcs_fb_t;

    // Frequency-select pins to feedback divider and charge pump
    function automatic prcs_fb_t prcs_decode(input logic [3:0] a, input logic [5:0] y);
        prcs_fb_t r;
        logic hi;
        r = '0;
        hi = (a == 4'hf);
        if ((a >= 4'h1 && a <= 4'hc) || hi) begin
            r.valid = 1'b1;
            r.cp = hi ? 8'h91 : 8'h79;
            if (y >= 6'h01 && y <= 6'h15) r.n = hi ? 20'd276480 : 20'd230400;
            else if (y >= 6'h16 && y <= 6'h1b) r.n = hi ? 20'd281250 : 20'd234375;
            else if (y >= 6'h1c && y <= 6'h21) r.n = hi ? 20'd279936 : 20'd233280;
            else if (y >= 6'h22 && y <= 6'h26) r.n = hi ? 20'd276480 : 20'd230400;
            else if (y >= 6'h27 && y <= 6'h2b) r.n = hi ? 20'd270000 : 20'd225000;
            else if (y == 6'h2c) r.n = hi ? 20'd277920 : 20'd231600;
            else r = '0;
        end else if (a == 4'hd && y >= 6'h2d && y <= 6'h32) begin
            r = '{1'b1, 20'd1512, 8'hff};
        end else if (a == 4'he && y == 6'h33) begin
            r = '{1'b1, 20'd768, 8'h79};
        end else if (a == 4'he && y == 6'h3f) begin
            r = '{1'b1, 20'd2400, 8'h79};
        end
        return r;
    endfunction
endpackage

// file: hdl/prcs_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prcs_if;
    logic [3:0] freq_select_group_a;
    logic [5:0] freq_select_group_y;
    logic ssop_clk;
    logic ssop_sel_n;
    logic ssop_dat_h_o;
    logic ssop_dat_h_oe;
    logic ssop_dat_d_o;
    logic ssop_dat_d_oe;
    logic ssop_dat;

    // Weak pull-up when nobody drives the data pin
    assign ssop_dat = ssop_dat_d_oe ? ssop_dat_d_o : (ssop_dat_h_oe ? ssop_dat_h_o : 1'b1);

    modport dev (
        input freq_select_group_a, freq_select_group_y, ssop_clk, ssop_sel_n, ssop_dat,
        output ssop_dat_d_o, ssop_dat_d_oe
    );
    modport host (
        output freq_select_group_a, freq_select_group_y, ssop_clk, ssop_sel_n,
        output ssop_dat_h_o, ssop_dat_h_oe,
        input ssop_dat
    );
endinterface
`default_nettype wire

// file: hdl/prcs_dev.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Serial mode on A=0000 or Y=000000
// - Shared pins go to serial or output-mode decoder
// - Ignore serial outside mode; hold output mode inside
// - Each function muxed by own enable bit
// - All enable bits reset to zero
// - Mux output switches on the next clock edge after enable set
// - Host writes values before setting enable
// - Divider enable selects registers 0x15-0x18
// - Calibrate when enabled and go written
// - Host loads PLL registers before calibration
// - Register control persists outside serial mode
// - Host uses serial pattern, programs, restores pins
// - A 0001-1100, Y 000001-010101: 230400, 121
// - Input A primary, B secondary
// - Differential mode: B complements A, no switchover
// - Crystal load defaults to 2 pF
// - Six-bit tuning field in 0.25 pF steps
// - Clearing bit 7 hands control to field
// - Calibration starts by itself after reset
module prcs_dev (
    input wire logic core_clk,
    input wire logic srst,
    prcs_if.dev bus,
    input wire logic [7:0] pin_div_zero,
    input wire logic [9:0] pin_div_one,
    input wire logic [9:0] pin_div_two,
    output logic spi_mode,
    output logic [2:0] out_mode,
    output logic [19:0] feedback_div,
    output logic [7:0] charge_pump_code,
    output logic fb_setting_valid,
    output logic [7:0] output_divider_zero,
    output logic [9:0] output_divider_one,
    output logic [9:0] output_divider_two,
    output logic [5:0] crystal_input_cap_code,
    output logic ref_differential,
    output logic switchover_enable,
    output logic vco_cal_active
);
    logic [7:0] vco_cal_reg;
    logic [7:0] div_ctrl_reg;
    logic [7:0] div_val_reg [4];
    logic [7:0] crystal_input_reg;
    logic [7:0] fb_reg [3];
    logic [7:0] cp_reg;
    logic [7:0] pll_ctrl_reg;
    logic [7:0] ref_cfg_reg;
    logic clk_q_reg;
    logic [4:0] bit_cnt_reg;
    logic [14:0] in_sh_reg;
    logic [7:0] out_sh_reg;
    logic rd_reg;
    logic [6:0] addr_reg;
    logic [4:0] cal_cnt_reg;
    logic spi_now;
    logic rise;
    logic wr_stb;
    logic [7:0] wr_data;
    logic [6:0] hdr_addr;
    logic [7:0] rd_data;
    logic cal_start;
    prcs_pkg::prcs_fb_t pin_fb;

    assign spi_now = (bus.freq_select_group_a == prcs_pkg::A_SPI)
        || (bus.freq_select_group_y == prcs_pkg::Y_SPI);
    assign rise = spi_now && !bus.ssop_sel_n && bus.ssop_clk && !clk_q_reg
        && (bit_cnt_reg < prcs_pkg::FRAME_BITS);
    assign hdr_addr = {in_sh_reg[5:0], bus.ssop_dat};
    assign wr_data = {in_sh_reg[6:0], bus.ssop_dat};
    assign wr_stb = rise && !rd_reg && (bit_cnt_reg == prcs_pkg::FRAME_BITS - 5'h01);
    assign pin_fb = prcs_pkg::prcs_decode(bus.freq_select_group_a,
        bus.freq_select_group_y);
    // Writing go with the enable set in the same write starts it
    assign cal_start = wr_stb && addr_reg == prcs_pkg::REG_VCO_CAL
        && wr_data[prcs_pkg::CAL_GO_BIT] && wr_data[prcs_pkg::CAL_EN_BIT];

    always_comb begin
        rd_data = 8'h00;
        unique case (hdr_addr)
            prcs_pkg::REG_VCO_CAL: rd_data = vco_cal_reg;
            prcs_pkg::REG_DIV_CTRL: rd_data = div_ctrl_reg;
            prcs_pkg::REG_DIV_VAL_A: rd_data = div_val_reg[0];
            prcs_pkg::REG_DIV_VAL_B: rd_data = div_val_reg[1];
            prcs_pkg::REG_DIV_VAL_C: rd_data = div_val_reg[2];
            prcs_pkg::REG_DIV_VAL_D: rd_data = div_val_reg[3];
            prcs_pkg::REG_CRYSTAL_INPUT: rd_data = crystal_input_reg;
            prcs_pkg::REG_FB_LO: rd_data = fb_reg[0];
            prcs_pkg::REG_FB_MID: rd_data = fb_reg[1];
            prcs_pkg::REG_FB_HI: rd_data = fb_reg[2];
            prcs_pkg::REG_CP: rd_data = cp_reg;
            prcs_pkg::REG_PLL_CTRL: rd_data = pll_ctrl_reg;
            prcs_pkg::REG_REF_CFG: rd_data = ref_cfg_reg;
            default: rd_data = 8'h00;
        endcase
    end

    // Serial shifter; frames outside serial mode are dropped whole
    always_ff @(posedge core_clk) begin
        clk_q_reg <= bus.ssop_clk;
        if (srst || bus.ssop_sel_n || !spi_now) begin
            bit_cnt_reg <= 5'h00;
            rd_reg <= 1'b0;
            bus.ssop_dat_d_oe <= 1'b0;
            out_sh_reg <= 8'h00;
            in_sh_reg <= 15'h0000;
            addr_reg <= 7'h00;
        end else if (rise) begin
            in_sh_reg <= {in_sh_reg[13:0], bus.ssop_dat};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == prcs_pkg::HDR_BITS - 5'h01) begin
                addr_reg <= hdr_addr;
                rd_reg <= in_sh_reg[6];
                bus.ssop_dat_d_oe <= in_sh_reg[6];
                out_sh_reg <= rd_data;
            end else if (bit_cnt_reg >= prcs_pkg::HDR_BITS) begin
                out_sh_reg <= {out_sh_reg[6:0], 1'b0};
            end
        end
    end
    assign bus.ssop_dat_d_o = out_sh_reg[7];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            vco_cal_reg <= 8'h00;
            div_ctrl_reg <= 8'h00;
            crystal_input_reg <= prcs_pkg::CRYSTAL_INPUT_RST;
            cp_reg <= 8'h00;
            pll_ctrl_reg <= 8'h00;
            ref_cfg_reg <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                div_val_reg[i] <= 8'h00;
            end
            for (int i = 0; i < 3; i++) begin
                fb_reg[i] <= 8'h00;
            end
        end else begin
            if (wr_stb) begin
                unique case (addr_reg)
                    prcs_pkg::REG_VCO_CAL: vco_cal_reg <= wr_data;
                    prcs_pkg::REG_DIV_CTRL: div_ctrl_reg <= wr_data;
                    prcs_pkg::REG_DIV_VAL_A: div_val_reg[0] <= wr_data;
                    prcs_pkg::REG_DIV_VAL_B: div_val_reg[1] <= wr_data;
                    prcs_pkg::REG_DIV_VAL_C: div_val_reg[2] <= wr_data;
                    prcs_pkg::REG_DIV_VAL_D: div_val_reg[3] <= wr_data;
                    prcs_pkg::REG_CRYSTAL_INPUT: crystal_input_reg <= wr_data;
                    prcs_pkg::REG_FB_LO: fb_reg[0] <= wr_data;
                    prcs_pkg::REG_FB_MID: fb_reg[1] <= wr_data;
                    prcs_pkg::REG_FB_HI: fb_reg[2] <= wr_data;
                    prcs_pkg::REG_CP: cp_reg <= wr_data;
                    prcs_pkg::REG_PLL_CTRL: pll_ctrl_reg <= wr_data;
                    prcs_pkg::REG_REF_CFG: ref_cfg_reg <= wr_data;
                    default: ;
                endcase
            end
            // Go bit reads as busy and clears itself when calibration ends
            if (cal_cnt_reg == 5'h01 && !(wr_stb && addr_reg == prcs_pkg::REG_VCO_CAL)) begin
                vco_cal_reg[prcs_pkg::CAL_GO_BIT] <= 1'b0;
            end
        end
    end

    // Counter loaded at reset so calibration runs with no command
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cal_cnt_reg <= prcs_pkg::CAL_CYCLES;
        end else if (cal_start) begin
            cal_cnt_reg <= prcs_pkg::CAL_CYCLES;
        end else if (cal_cnt_reg != 5'h00) begin
            cal_cnt_reg <= cal_cnt_reg - 5'h01;
        end
    end

    // Muxes read live enables, so a set bit acts on the next edge
    always_ff @(posedge core_clk) begin
        if (srst) begin
            spi_mode <= 1'b0;
            out_mode <= 3'h0;
            feedback_div <= 20'h00000;
            charge_pump_code <= 8'h00;
            fb_setting_valid <= 1'b0;
            output_divider_zero <= 8'h00;
            output_divider_one <= 10'h000;
            output_divider_two <= 10'h000;
            crystal_input_cap_code <= prcs_pkg::CRYSTAL_INPUT_DEF_CODE;
            ref_differential <= 1'b0;
            switchover_enable <= 1'b1;
            vco_cal_active <= 1'b0;
        end else begin
            spi_mode <= spi_now;
            if (!spi_now) begin
                out_mode <= {bus.ssop_sel_n, bus.ssop_dat, bus.ssop_clk};
            end
            if (pll_ctrl_reg[prcs_pkg::PLL_EN_BIT]) begin
                feedback_div <= {fb_reg[2][3:0], fb_reg[1], fb_reg[0]};
                charge_pump_code <= cp_reg;
                fb_setting_valid <= 1'b1;
            end else begin
                feedback_div <= pin_fb.n;
                charge_pump_code <= pin_fb.cp;
                fb_setting_valid <= pin_fb.valid;
            end
            if (div_ctrl_reg[prcs_pkg::DIV_EN_BIT]) begin
                output_divider_zero <= div_val_reg[0];
                output_divider_one <= {div_val_reg[2][1:0], div_val_reg[1]};
                output_divider_two <= {div_val_reg[2][5:4], div_val_reg[3]};
            end else begin
                output_divider_zero <= pin_div_zero;
                output_divider_one <= pin_div_one;
                output_divider_two <= pin_div_two;
            end
            if (crystal_input_reg[prcs_pkg::CRYSTAL_INPUT_PIN_BIT]) begin
                crystal_input_cap_code <= prcs_pkg::CRYSTAL_INPUT_DEF_CODE;
            end else begin
                crystal_input_cap_code <= crystal_input_reg[5:0];
            end
            ref_differential <= ref_cfg_reg[prcs_pkg::REF_DIFF_BIT];
            switchover_enable <= !ref_cfg_reg[prcs_pkg::REF_DIFF_BIT];
            vco_cal_active <= (cal_cnt_reg != 5'h00);
        end
    end
endmodule // prcs_dev
`default_nettype wire

// file: hdl/prcs_host.sv
`timescale 1ns/1ps
`default_nettype none
module prcs_host (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    prcs_if.host bus
);
    typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_END} prcs_hst_t;
    prcs_hst_t state_reg;
    logic rd_mode_reg;
    logic [6:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic [9:0] pins_reg;
    logic [2:0] omode_reg;
    logic [15:0] sh_reg;
    logic [4:0] bit_cnt_reg;
    logic [2:0] div_reg;
    logic wb_hit;
    logic go;
    logic spi_pat;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign spi_pat = (pins_reg[3:0] == prcs_pkg::A_SPI) || (pins_reg[9:4] == prcs_pkg::Y_SPI);
    // A transfer outside serial mode would be ignored, so it is refused here
    assign go = wb_hit && wb_we_i && wb_adr_i == prcs_pkg::HW_CTRL && wb_sel_i[0]
        && wb_dat_i[prcs_pkg::CTRL_GO_BIT] && state_reg == ST_IDLE && spi_pat;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            addr_reg <= 7'h00;
            wdata_reg <= 8'h00;
            pins_reg <= 10'h000;
            omode_reg <= 3'h0;
            rd_mode_reg <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h00000000;
            if (wb_hit && wb_we_i && wb_sel_i[0]) begin
                unique case (wb_adr_i)
                    prcs_pkg::HW_CTRL: begin
                        if (state_reg == ST_IDLE) begin
                            rd_mode_reg <= wb_dat_i[prcs_pkg::CTRL_RD_BIT];
                        end
                    end
                    prcs_pkg::HW_ADDR: addr_reg <= wb_dat_i[6:0];
                    prcs_pkg::HW_WDATA: wdata_reg <= wb_dat_i[7:0];
                    prcs_pkg::HW_PINS: pins_reg[7:0] <= wb_dat_i[7:0];
                    prcs_pkg::HW_OMODE: omode_reg <= wb_dat_i[2:0];
                    default: ;
                endcase
            end
            if (wb_hit && wb_we_i && wb_sel_i[1] && wb_adr_i == prcs_pkg::HW_PINS) begin
                pins_reg[9:8] <= wb_dat_i[9:8];
            end
            if (wb_hit && !wb_we_i) begin
                unique case (wb_adr_i)
                    prcs_pkg::HW_CTRL: wb_dat_o <= {30'h0, rd_mode_reg, 1'b0};
                    prcs_pkg::HW_ADDR: wb_dat_o <= {25'h0, addr_reg};
                    prcs_pkg::HW_WDATA: wb_dat_o <= {24'h0, wdata_reg};
                    prcs_pkg::HW_RDATA: wb_dat_o <= {24'h0, rdata_reg};
                    prcs_pkg::HW_STATUS: wb_dat_o <= {30'h0, spi_pat, state_reg != ST_IDLE};
                    prcs_pkg::HW_PINS: wb_dat_o <= {22'h0, pins_reg};
                    prcs_pkg::HW_OMODE: wb_dat_o <= {29'h0, omode_reg};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

    // Serial master; pins carry the output mode when idle outside the serial pattern
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            sh_reg <= 16'h0000;
            bit_cnt_reg <= 5'h00;
            div_reg <= 3'h0;
            rdata_reg <= 8'h00;
            bus.ssop_clk <= 1'b0;
            bus.ssop_sel_n <= 1'b0;
            bus.ssop_dat_h_o <= 1'b0;
            bus.ssop_dat_h_oe <= 1'b0;
            bus.freq_select_group_a <= 4'h0;
            bus.freq_select_group_y <= 6'h00;
        end else begin
            bus.freq_select_group_a <= pins_reg[3:0];
            bus.freq_select_group_y <= pins_reg[9:4];
            unique case (state_reg)
                ST_IDLE: begin
                    {bus.ssop_sel_n, bus.ssop_dat_h_o, bus.ssop_clk} <= spi_pat ? 3'h4 : omode_reg;
                    bus.ssop_dat_h_oe <= 1'b1;
                    if (go) begin
                        sh_reg <= {wb_dat_i[prcs_pkg::CTRL_RD_BIT], addr_reg, wdata_reg};
                        bit_cnt_reg <= 5'h00;
                        div_reg <= 3'h0;
                        bus.ssop_sel_n <= 1'b1;
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    bus.ssop_sel_n <= 1'b0;
                    bus.ssop_clk <= 1'b0;
                    bus.ssop_dat_h_o <= sh_reg[15];
                    bus.ssop_dat_h_oe <= !(rd_mode_reg && bit_cnt_reg >= prcs_pkg::HDR_BITS);
                    div_reg <= div_reg + 3'h1;
                    if (div_reg == prcs_pkg::SCLK_HALF - 3'h1) begin
                        div_reg <= 3'h0;
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (div_reg == 3'h0) begin
                        bus.ssop_clk <= 1'b1;
                        sh_reg <= {sh_reg[14:0], 1'b0};
                        if (bit_cnt_reg >= prcs_pkg::HDR_BITS) begin
                            rdata_reg <= {rdata_reg[6:0], bus.ssop_dat};
                        end
                    end
                    div_reg <= div_reg + 3'h1;
                    if (div_reg == prcs_pkg::SCLK_HALF - 3'h1) begin
                        div_reg <= 3'h0;
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        state_reg <= (bit_cnt_reg == prcs_pkg::FRAME_BITS - 5'h01) ? ST_END : ST_LOW;
                    end
                end
                ST_END: begin
                    bus.ssop_clk <= 1'b0;
                    bus.ssop_sel_n <= 1'b1;
                    bus.ssop_dat_h_oe <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // prcs_host
`default_nettype wire

// file: verif/prcs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module prcs_checker (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [3:0] freq_select_group_a,
    input wire logic [5:0] freq_select_group_y,
    input wire logic ssop_clk,
    input wire logic ssop_sel_n,
    input wire logic ssop_dat,
    input wire logic ssop_dat_d_oe,
    input wire logic spi_mode,
    input wire logic [2:0] out_mode,
    input wire logic [7:0] pin_div_zero,
    input wire logic [7:0] output_divider_zero,
    input wire logic [5:0] crystal_input_cap_code,
    input wire logic vco_cal_active
);
    logic pat;
    assign pat = (freq_select_group_a == 4'h0) || (freq_select_group_y == 6'h00);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_in_mode; spi_mode[*3]; endsequence
    sequence s_pin_mode; !spi_mode ##1 !spi_mode ##1 !spi_mode; endsequence
    sequence s_cal_run; vco_cal_active[*8]; endsequence
    a_mode_decode: assert property (
        !$past(srst) |-> spi_mode == $past(pat)) else $error("serial mode decode wrong");
    a_omode_pass: assert property (
        s_pin_mode |-> out_mode == $past({ssop_sel_n, ssop_dat, ssop_clk}))
        else $error("output mode not taken from shared pins");
    a_omode_hold: assert property (
        s_in_mode |-> $stable(out_mode)) else $error("output mode moved in serial mode");
    a_dev_quiet: assert property (
        !spi_mode ##1 !spi_mode |-> !ssop_dat_d_oe) else $error("device drove data outside mode");
    a_read_oe: assert property (
        $rose(ssop_dat_d_oe) |-> !ssop_sel_n && spi_mode) else $error("data drive unselected");
    a_reset_pins: assert property (
        $fell(srst) |=> output_divider_zero == $past(pin_div_zero))
        else $error("divider not pin sourced after reset");
    a_crystal_input_default: assert property (
        $fell(srst) |-> crystal_input_cap_code == 6'h08) else $error("crystal load default wrong");
    a_cal_auto: assert property (
        $fell(srst) |-> ##[0:2] s_cal_run) else $error("no calibration after reset");
    a_cal_len: assert property (
        $rose(vco_cal_active) |-> s_cal_run) else $error("calibration cut short");
    a_cal_end: assert property (
        $rose(vco_cal_active) |-> ##[8:24] !vco_cal_active) else $error("calibration never ends");
endmodule // prcs_checker
`default_nettype wire

// file: verif/tb_pin_register_control_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_pin_register_control_select;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rd;
    logic wb_ack;
    logic [7:0] pin_div_zero = 8'ha5;
    logic [9:0] pin_div_one = 10'h2c3;
    logic [9:0] pin_div_two = 10'h19e;
    logic spi_mode, fb_setting_valid, ref_differential, switchover_enable, vco_cal_active;
    logic [2:0] out_mode;
    logic [19:0] feedback_div;
    logic [7:0] charge_pump_code, output_divider_zero, q;
    logic [9:0] output_divider_one, output_divider_two;
    logic [5:0] crystal_input_cap_code;
    logic [31:0] r;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [9:0] tp [10] = '{10'h050, 10'h003, 10'h011, 10'h15c, 10'h2c1,
        10'h2d3, 10'h33e, 10'h2dd, 10'h01f, 10'h3ff};
    logic [29:0] te [10] = '{{2'b10, 28'h0}, {2'b10, 28'h0}, {2'b01, 20'd230400, 8'd121},
        {2'b01, 20'd230400, 8'd121}, {2'b01, 20'd231600, 8'd121}, 30'h0,
        {2'b01, 20'd768, 8'd121}, {2'b01, 20'd1512, 8'd255}, {2'b01, 20'd276480, 8'd145}, 30'h0};
    logic [7:0] xv [3] = '{8'h3f, 8'h15, 8'h95};
    logic [5:0] xe [3] = '{6'h3f, 6'h15, 6'h08};

    prcs_if u_prcs_if();
    prcs_dev u_prcs_dev(.core_clk, .srst, .bus(u_prcs_if), .pin_div_zero, .pin_div_one,
        .pin_div_two, .spi_mode, .out_mode, .feedback_div, .charge_pump_code,
        .fb_setting_valid, .output_divider_zero, .output_divider_one, .output_divider_two,
        .crystal_input_cap_code, .ref_differential, .switchover_enable, .vco_cal_active);
    prcs_host u_prcs_host(.core_clk, .srst, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(4'h3),
        .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .bus(u_prcs_if));
    prcs_checker u_prcs_checker(.core_clk, .srst,
        .freq_select_group_a(u_prcs_if.freq_select_group_a),
        .freq_select_group_y(u_prcs_if.freq_select_group_y), .ssop_clk(u_prcs_if.ssop_clk),
        .ssop_sel_n(u_prcs_if.ssop_sel_n), .ssop_dat(u_prcs_if.ssop_dat),
        .ssop_dat_d_oe(u_prcs_if.ssop_dat_d_oe), .spi_mode, .out_mode, .pin_div_zero,
        .output_divider_zero, .crystal_input_cap_code, .vco_cal_active);

    initial forever #5 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Ceiling leaves ample slack over the longest serial sequence
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            fail_count++;
            give_verdict();
        end
    end

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, adr, dat};
        @(posedge core_clk);
        while (wb_ack !== 1'b1) @(posedge core_clk);
        r = wb_rd;
        {wb_cyc, wb_stb} <= 2'b00;
        @(posedge core_clk);
    endtask

    // One serial frame through the host, then wait for it to go idle
    task automatic dev(input logic rd, input logic [6:0] a, input logic [7:0] d);
        wb(1'b1, prcs_pkg::HW_ADDR, {25'h0, a});
        wb(1'b1, prcs_pkg::HW_WDATA, {24'h0, d});
        wb(1'b1, prcs_pkg::HW_CTRL, {30'h0, rd, 1'b1});
        r = 32'h1;
        while (r[0] !== 1'b0) wb(1'b0, prcs_pkg::HW_STATUS, 32'h0);
        wb(1'b0, prcs_pkg::HW_RDATA, 32'h0);
        q = r[7:0];
        repeat (2) @(posedge core_clk);
    endtask

    task automatic pins(input logic [9:0] ya);
        wb(1'b1, prcs_pkg::HW_PINS, {22'h0, ya});
        repeat (3) @(posedge core_clk);
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk("reset outs", {crystal_input_cap_code, switchover_enable, ref_differential}, 8'h22);
        repeat (3) @(posedge core_clk);
        chk("auto cal", vco_cal_active, 1'b1);
        repeat (20) @(posedge core_clk);
        chk("cal done", vco_cal_active, 1'b0);
        chk("div pins", {spi_mode, output_divider_zero}, {1'b1, pin_div_zero});
        dev(1'b1, prcs_pkg::REG_CRYSTAL_INPUT, 8'h00);
        chk("crystal_input reg", q, 8'hbf);
        dev(1'b1, prcs_pkg::REG_DIV_CTRL, 8'h00);
        chk("div ctrl", q, 8'h00);
        dev(1'b0, prcs_pkg::REG_DIV_VAL_A, 8'h3c);
        dev(1'b0, prcs_pkg::REG_DIV_VAL_B, 8'h5a);
        dev(1'b0, prcs_pkg::REG_DIV_VAL_C, 8'h21);
        dev(1'b0, prcs_pkg::REG_DIV_VAL_D, 8'h77);
        chk("div held", output_divider_zero, pin_div_zero);
        dev(1'b1, prcs_pkg::REG_DIV_VAL_B, 8'h00);
        chk("div b", q, 8'h5a);
        dev(1'b0, prcs_pkg::REG_DIV_CTRL, 8'h04);
        chk("div regs", {output_divider_zero, output_divider_one, output_divider_two},
            {8'h3c, 10'h15a, 10'h277});
        wb(1'b1, prcs_pkg::HW_OMODE, 32'h5);
        pins(10'h011);
        chk("omode", out_mode, 3'h5);
        chk("div kept", output_divider_zero, 8'h3c);
        // A transfer requested outside serial mode is refused and must leave the register untouched
        dev(1'b0, prcs_pkg::REG_DIV_VAL_A, 8'h99);
        pins(10'h000);
        chk("omode held", out_mode, 3'h5);
        dev(1'b1, prcs_pkg::REG_DIV_VAL_A, 8'h00);
        chk("no write", q, 8'h3c);
        dev(1'b0, prcs_pkg::REG_DIV_CTRL, 8'h00);
        chk("div back", output_divider_zero, pin_div_zero);
        for (int i = 0; i < 10; i++) begin
            pins(tp[i]);
            chk("decode", {spi_mode, fb_setting_valid, feedback_div, charge_pump_code},
                te[i]);
        end
        pins(10'h000);
        dev(1'b0, prcs_pkg::REG_FB_MID, 8'h84);
        dev(1'b0, prcs_pkg::REG_FB_HI, 8'h03);
        dev(1'b0, prcs_pkg::REG_CP, 8'h79);
        dev(1'b0, prcs_pkg::REG_PLL_CTRL, 8'h01);
        chk("fb regs", {fb_setting_valid, feedback_div, charge_pump_code},
            {1'b1, 20'd230400, 8'd121});
        dev(1'b0, prcs_pkg::REG_VCO_CAL, 8'h80);
        chk("cal off", vco_cal_active, 1'b0);
        dev(1'b0, prcs_pkg::REG_VCO_CAL, 8'h84);
        chk("cal on", vco_cal_active, 1'b1);
        for (int i = 0; i < 3; i++) begin
            dev(1'b0, prcs_pkg::REG_CRYSTAL_INPUT, xv[i]);
            chk("crystal_input code", crystal_input_cap_code, xe[i]);
        end
        dev(1'b0, prcs_pkg::REG_REF_CFG, 8'h01);
        chk("ref diff", {ref_differential, switchover_enable}, 2'b10);
        wb(1'b1, 8'h1c, 32'hff);
        wb(1'b0, 8'h1c, 32'h0);
        chk("unmapped", r, 32'h0);
        give_verdict();
    end
endmodule // tb_pin_register_control_select
`default_nettype wire
